/* psm_pkg.sv */
// Shared constants for the power and system management signalling block
package psm_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned FILTER_TIME_MS  = 16;
    localparam int unsigned FILTER_CYCLES   = (CLK_HZ / 1000) * FILTER_TIME_MS;
    localparam int unsigned RST_PULSE_MS    = 1;
    localparam int unsigned RST_PULSE_CYC   = (CLK_HZ / 1000) * RST_PULSE_MS;
    localparam int unsigned PEND_TIME_US    = 2;
    localparam int unsigned PEND_CYCLES     = (CLK_HZ / 1_000_000) * PEND_TIME_US;

    // Filtered input channel indices
    localparam int unsigned IN_PWR_BTN  = 0;
    localparam int unsigned IN_RST_BTN  = 1;
    localparam int unsigned IN_LID      = 2;
    localparam int unsigned IN_SLEEP    = 3;
    localparam int unsigned IN_WAKE_PCI = 4;
    localparam int unsigned IN_WAKE_GEN = 5;
    localparam int unsigned IN_BAT_LOW  = 6;
    localparam int unsigned IN_OVER_TMP = 7;
    localparam int unsigned IN_ALERT    = 8;
    localparam int unsigned NUM_IN      = 9;

    // System power states, one-hot
    typedef enum logic [4:0] {
        PSM_SOFT_OFF = 5'h01,
        PSM_RUN      = 5'h02,
        PSM_PENDING  = 5'h04,
        PSM_RAM      = 5'h08,
        PSM_DISK     = 5'h10
    } psm_state_t;
endpackage

/* psm_top.sv */
// Power and system management signalling: input filters, power states, carrier reset
`timescale 1ns/1ns

module psm_filter #(
    parameter int unsigned STABLE = psm_pkg::FILTER_CYCLES,
    parameter int unsigned CNT_W  = $clog2(STABLE + 1)
) (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic raw_n,
    output logic      level_n,
    output logic      fall,
    output logic      rise
);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(STABLE - 1);

    typedef struct packed {
        logic             sync1;
        logic             sync2;
        logic             level;
        logic [CNT_W-1:0] cnt;
        logic             fall;
        logic             rise;
    } psm_flt_t;

    psm_flt_t st_reg;
    psm_flt_t st_next;

    // Two-stage synchroniser then a stability counter; idle level is high (pulled up)
    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = raw_n;
        st_next.sync2 = st_reg.sync1;
        st_next.fall  = 1'b0;
        st_next.rise  = 1'b0;
        if (st_reg.sync2 == st_reg.level) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt == LAST) begin
            // Only a level held for the whole window is accepted
            st_next.cnt   = '0;
            st_next.level = st_reg.sync2;
            st_next.fall  = ~st_reg.sync2;
            st_next.rise  = st_reg.sync2;
        end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '{sync1: 1'b1, sync2: 1'b1, level: 1'b1, cnt: '0, fall: 1'b0, rise: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_n = st_reg.level;
    assign fall    = st_reg.fall;
    assign rise    = st_reg.rise;
endmodule

module psm_top #(
    parameter int unsigned FILTER_CYCLES = psm_pkg::FILTER_CYCLES,
    parameter int unsigned RST_PULSE_CYC = psm_pkg::RST_PULSE_CYC,
    parameter int unsigned PEND_CYCLES   = psm_pkg::PEND_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic power_button_n,
    input  wire logic reset_button_n,
    input  wire logic supply_good,
    input  wire logic main_supply_low,
    input  wire logic watchdog_timeout,
    input  wire logic sw_reset_req,
    input  wire logic suspend_ram_req,
    input  wire logic suspend_disk_req,
    input  wire logic cpu_thermal_shutdown,
    input  wire logic pcie_wake_n,
    input  wire logic general_wake_n,
    input  wire logic battery_low_n,
    input  wire logic over_temp_in_n,
    input  wire logic mgmt_bus_alert_n,
    input  wire logic lid_n,
    input  wire logic sleep_button_n,
    output logic      carrier_reset_n,
    output logic      suspend_pending_n,
    output logic      suspend_ram_n,
    output logic      suspend_disk_n,
    output logic      soft_off_n,
    output logic      thermal_trip_n,
    output logic      system_mgmt_interrupt_n,
    output logic      power_button_evt,
    output logic      lid_evt,
    output logic      sleep_button_evt,
    output logic      power_mgmt_evt,
    output logic      over_temp_evt,
    output logic      wake_evt
);
    localparam int unsigned RST_W  = $clog2(RST_PULSE_CYC + 1);
    localparam int unsigned PEND_W = $clog2(PEND_CYCLES + 1);
    localparam logic [RST_W-1:0]  RST_LOAD  = RST_W'(RST_PULSE_CYC);
    localparam logic [PEND_W-1:0] PEND_LAST = PEND_W'(PEND_CYCLES - 1);
    localparam int unsigned N = psm_pkg::NUM_IN;

    typedef struct packed {
        psm_pkg::psm_state_t state;
        logic                to_disk;
        logic [PEND_W-1:0]   pend_cnt;
        logic [RST_W-1:0]    rst_cnt;
        logic                carrier_reset_n;
        logic                suspend_pending_n;
        logic                suspend_ram_n;
        logic                suspend_disk_n;
        logic                thermal_trip_n;
        logic                smi_n;
        logic                pwr_evt;
        logic                lid_evt;
        logic                sleep_evt;
        logic                pm_evt;
        logic                ot_evt;
        logic                wake_evt;
    } psm_top_t;

    psm_top_t     st_reg;
    psm_top_t     st_next;
    logic [N-1:0] raw_n;
    logic [N-1:0] lvl_n;
    logic [N-1:0] fall;
    logic         wake_any;

    assign raw_n = {mgmt_bus_alert_n, over_temp_in_n, battery_low_n, general_wake_n, pcie_wake_n,
                    sleep_button_n, lid_n, reset_button_n, power_button_n};

    // One filter per button or event input
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_flt
            psm_filter #(
                .STABLE (FILTER_CYCLES)
            ) u_flt (
                .clk_sys (clk_sys),
                .arst_n  (arst_n),
                .raw_n   (raw_n[gi]),
                .level_n (lvl_n[gi]),
                .fall    (fall[gi]),
                .rise    ()
            );
        end
    endgenerate

    // Wake sources for a suspended system; alert wakes as well as interrupting
    assign wake_any = fall[psm_pkg::IN_PWR_BTN] | fall[psm_pkg::IN_SLEEP]
                    | fall[psm_pkg::IN_WAKE_PCI] | fall[psm_pkg::IN_WAKE_GEN]
                    | fall[psm_pkg::IN_ALERT];

    always_comb begin
        st_next           = st_reg;
        st_next.pwr_evt   = fall[psm_pkg::IN_PWR_BTN];
        st_next.lid_evt   = fall[psm_pkg::IN_LID];
        st_next.sleep_evt = fall[psm_pkg::IN_SLEEP];
        st_next.pm_evt    = fall[psm_pkg::IN_BAT_LOW];
        st_next.ot_evt    = fall[psm_pkg::IN_OVER_TMP];
        st_next.smi_n     = lvl_n[psm_pkg::IN_ALERT];
        st_next.wake_evt  = 1'b0;

        // Reset pulse is timed, so a button held low cannot keep the carrier in reset
        if (fall[psm_pkg::IN_RST_BTN] || watchdog_timeout || sw_reset_req) begin
            st_next.rst_cnt = RST_LOAD;
        end else if (st_reg.rst_cnt != '0) begin
            st_next.rst_cnt = st_reg.rst_cnt - 1'b1;
        end
        // Supply faults hold reset for as long as they last
        st_next.carrier_reset_n = supply_good && !main_supply_low
                                && (st_next.rst_cnt == '0);

        // Thermal trip stays latched until the next power-on reset
        if (cpu_thermal_shutdown) begin
            st_next.thermal_trip_n = 1'b0;
        end

        case (st_reg.state)
            psm_pkg::PSM_SOFT_OFF: begin
                if (fall[psm_pkg::IN_PWR_BTN]) begin
                    st_next.state    = psm_pkg::PSM_RUN;
                    st_next.wake_evt = 1'b1;
                end
            end
            psm_pkg::PSM_RUN: begin
                if (suspend_disk_req || suspend_ram_req) begin
                    st_next.state    = psm_pkg::PSM_PENDING;
                    st_next.to_disk  = suspend_disk_req;
                    st_next.pend_cnt = '0;
                end
            end
            psm_pkg::PSM_PENDING: begin
                // Announce the suspend before the rails are dropped
                if (st_reg.pend_cnt == PEND_LAST) begin
                    st_next.state = st_reg.to_disk ? psm_pkg::PSM_DISK : psm_pkg::PSM_RAM;
                end else begin
                    st_next.pend_cnt = st_reg.pend_cnt + 1'b1;
                end
            end
            psm_pkg::PSM_RAM, psm_pkg::PSM_DISK: begin
                if (wake_any) begin
                    st_next.state    = psm_pkg::PSM_RUN;
                    st_next.wake_evt = 1'b1;
                end
            end
            default: begin
                st_next.state = psm_pkg::PSM_SOFT_OFF;
            end
        endcase

        // Suspend indicators decoded from the next state; soft-off also drops both
        st_next.suspend_pending_n = (st_next.state != psm_pkg::PSM_PENDING);
        st_next.suspend_ram_n     = (st_next.state == psm_pkg::PSM_RUN)
                                  || (st_next.state == psm_pkg::PSM_PENDING);
        st_next.suspend_disk_n    = (st_next.state != psm_pkg::PSM_DISK)
                                  && (st_next.state != psm_pkg::PSM_SOFT_OFF);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '{state: psm_pkg::PSM_SOFT_OFF, to_disk: 1'b0, pend_cnt: '0, rst_cnt: '0,
                        carrier_reset_n: 1'b0, suspend_pending_n: 1'b1, suspend_ram_n: 1'b0,
                        suspend_disk_n: 1'b0, thermal_trip_n: 1'b1, smi_n: 1'b1, pwr_evt: 1'b0,
                        lid_evt: 1'b0, sleep_evt: 1'b0, pm_evt: 1'b0, ot_evt: 1'b0,
                        wake_evt: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign carrier_reset_n         = st_reg.carrier_reset_n;
    assign suspend_pending_n       = st_reg.suspend_pending_n;
    assign suspend_ram_n           = st_reg.suspend_ram_n;
    assign suspend_disk_n          = st_reg.suspend_disk_n;
    assign soft_off_n              = st_reg.suspend_disk_n;
    assign thermal_trip_n          = st_reg.thermal_trip_n;
    assign system_mgmt_interrupt_n = st_reg.smi_n;
    assign power_button_evt        = st_reg.pwr_evt;
    assign lid_evt                 = st_reg.lid_evt;
    assign sleep_button_evt        = st_reg.sleep_evt;
    assign power_mgmt_evt          = st_reg.pm_evt;
    assign over_temp_evt           = st_reg.ot_evt;
    assign wake_evt                = st_reg.wake_evt;
endmodule

/* psm_properties.sv */
// Port-level checker for the power and system management block
`timescale 1ns/1ns
module psm_checker (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic supply_good,
    input wire logic main_supply_low,
    input wire logic watchdog_timeout,
    input wire logic sw_reset_req,
    input wire logic cpu_thermal_shutdown,
    input wire logic lid_n,
    input wire logic carrier_reset_n,
    input wire logic suspend_pending_n,
    input wire logic suspend_ram_n,
    input wire logic suspend_disk_n,
    input wire logic soft_off_n,
    input wire logic thermal_trip_n,
    input wire logic lid_evt,
    input wire logic wake_evt
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // A pulse source must hold the reset for at least eight cycles
    sequence rst_pulse;
        !carrier_reset_n [*8];
    endsequence
    // End of the pending window
    sequence pend_end;
        !suspend_pending_n ##1 suspend_pending_n;
    endsequence
    a_soft_off_copy: assert property (soft_off_n == suspend_disk_n)
        else $error("soft-off output differs from suspend-to-disk");
    a_pulse_reset: assert property ((watchdog_timeout || sw_reset_req) |=> rst_pulse)
        else $error("pulse reset source did not hold carrier reset");
    a_supply_reset: assert property ((!supply_good || main_supply_low) |=> !carrier_reset_n)
        else $error("bad supply did not drive carrier reset");
    a_pend_first: assert property ($fell(suspend_ram_n) |-> !$past(suspend_pending_n))
        else $error("suspend entered without pending notice");
    a_pend_exit: assert property (pend_end |-> !suspend_ram_n)
        else $error("pending ended without suspend-to-RAM low");
    a_disk_deep: assert property (!suspend_disk_n |-> !suspend_ram_n)
        else $error("suspend-to-disk without RAM indicator low");
    a_trip_latch: assert property (cpu_thermal_shutdown |=> !thermal_trip_n [*3])
        else $error("thermal trip output not low after shutdown");
    a_wake_run: assert property (wake_evt |-> suspend_ram_n && suspend_disk_n && suspend_pending_n)
        else $error("wake event without running state");
    a_lid_stable: assert property (lid_evt |-> !$past(lid_n, 8))
        else $error("lid event without a stable low input");
    a_lid_single: assert property (lid_evt |=> !lid_evt)
        else $error("lid event longer than one cycle");
endmodule
bind psm_top psm_checker psm_checker_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .supply_good(supply_good), .main_supply_low(main_supply_low),
    .watchdog_timeout(watchdog_timeout), .sw_reset_req(sw_reset_req), .cpu_thermal_shutdown(cpu_thermal_shutdown),
    .lid_n(lid_n), .carrier_reset_n(carrier_reset_n), .suspend_pending_n(suspend_pending_n),
    .suspend_ram_n(suspend_ram_n), .suspend_disk_n(suspend_disk_n), .soft_off_n(soft_off_n),
    .thermal_trip_n(thermal_trip_n), .lid_evt(lid_evt), .wake_evt(wake_evt)
);

/* psm_carrier.sv */
// Carrier board model: buttons, event lines and main supply
`timescale 1ns/1ns
module psm_carrier (
    input  wire logic clk_sys,
    output logic [8:0] line_n,
    output logic       supply_good,
    output logic       main_supply_low
);
    // Pull-ups hold every released line high; supply starts good
    initial begin
        line_n          = 9'h1FF;
        supply_good     = 1'b1;
        main_supply_low = 1'b0;
    end
    // Hold one line low; a short len makes a glitch the filter must drop
    task automatic press(input int idx, input int len);
        @(posedge clk_sys) line_n[idx] <= 1'b0;
        repeat (len) @(posedge clk_sys);
        line_n[idx] <= 1'b1;
        // Stay released long enough that the next fall is a fresh edge
        repeat (12) @(posedge clk_sys);
    endtask
endmodule

/* tb.sv */
// Self-checking testbench for the power and system management block
`timescale 1ns/1ns
module tb;
    localparam int FC = 8;
    localparam int RC = 10;
    localparam int PC = 4;
    logic       clk_sys = 1'b0;
    logic       arst_n = 1'b0;
    logic       watchdog_timeout = 1'b0, sw_reset_req = 1'b0, cpu_thermal_shutdown = 1'b0;
    logic       suspend_ram_req = 1'b0, suspend_disk_req = 1'b0;
    logic [8:0] line_n;
    logic       supply_good, main_supply_low, carrier_reset_n, suspend_pending_n, suspend_ram_n;
    logic       suspend_disk_n, soft_off_n, thermal_trip_n, system_mgmt_interrupt_n;
    logic [5:0] evts;
    int         errors = 0;
    int         samples_checked = 0;
    always #25 clk_sys = ~clk_sys;
    psm_carrier car_inst (.clk_sys(clk_sys), .line_n(line_n), .supply_good(supply_good),
        .main_supply_low(main_supply_low));
    psm_top #(.FILTER_CYCLES(FC), .RST_PULSE_CYC(RC), .PEND_CYCLES(PC)) psm_top_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .power_button_n(line_n[0]), .reset_button_n(line_n[1]),
        .supply_good(supply_good), .main_supply_low(main_supply_low), .watchdog_timeout(watchdog_timeout),
        .sw_reset_req(sw_reset_req), .suspend_ram_req(suspend_ram_req), .suspend_disk_req(suspend_disk_req),
        .cpu_thermal_shutdown(cpu_thermal_shutdown), .pcie_wake_n(line_n[4]), .general_wake_n(line_n[5]),
        .battery_low_n(line_n[6]), .over_temp_in_n(line_n[7]), .mgmt_bus_alert_n(line_n[8]), .lid_n(line_n[2]),
        .sleep_button_n(line_n[3]), .carrier_reset_n(carrier_reset_n), .suspend_pending_n(suspend_pending_n),
        .suspend_ram_n(suspend_ram_n), .suspend_disk_n(suspend_disk_n), .soft_off_n(soft_off_n),
        .thermal_trip_n(thermal_trip_n), .system_mgmt_interrupt_n(system_mgmt_interrupt_n),
        .power_button_evt(evts[0]), .lid_evt(evts[1]), .sleep_button_evt(evts[2]), .power_mgmt_evt(evts[3]),
        .over_temp_evt(evts[4]), .wake_evt(evts[5]));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Press a line and note whether event bit b pulsed meanwhile
    task automatic press_see(input int idx, input int len, input int b, input logic exp);
        logic seen;
        seen = 1'b0;
        fork
            car_inst.press(idx, len);
            repeat (FC + 12) @(negedge clk_sys) seen |= evts[b];
        join
        check(seen, exp);
    endtask
    // Length of the next carrier reset pulse; a missing pulse ends the run
    task automatic low_len(output int n);
        int i;
        n = 0;
        @(negedge clk_sys);
        for (i = 0; i < 40 && carrier_reset_n; i++) @(negedge clk_sys);
        while (!carrier_reset_n && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        if (i == 40 || n == 60) begin
            errors++;
            give_verdict();
        end
    endtask
    // Glitch refused, then a full press leaves soft-off
    task automatic t_power();
        press_see(0, 4, 0, 0);
        press_see(0, FC + 4, 0, 1);
        check({suspend_ram_n, suspend_disk_n}, 2'h3);
    endtask
    // Lid, sleep, battery-low and over-temperature each give their event
    task automatic t_events();
        int ln[4] = '{2, 3, 6, 7};
        for (int k = 0; k < 4; k++) press_see(ln[k], FC + 4, k + 1, 1);
    endtask
    // Watchdog, software, supply-good and main-supply sources
    // A supply fault seen on six edges holds reset exactly six cycles
    task automatic t_sources();
        int n;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            watchdog_timeout <= (k == 0);
            sw_reset_req <= (k == 1);
            car_inst.supply_good <= (k != 2);
            car_inst.main_supply_low <= (k == 3);
            fork
                low_len(n);
                begin
                    @(posedge clk_sys);
                    {watchdog_timeout, sw_reset_req} <= 2'h0;
                    if (k > 1) repeat (5) @(posedge clk_sys);
                    car_inst.supply_good <= 1'b1;
                    car_inst.main_supply_low <= 1'b0;
                end
            join
            check(n, k > 1 ? 6 : RC);
        end
    endtask
    // A held reset button gives one pulse, then the carrier leaves reset
    task automatic t_rstbtn();
        int n;
        fork
            car_inst.press(1, FC + 40);
            begin
                low_len(n);
                check(n, RC);
                check(carrier_reset_n, 1);
            end
        join
    endtask
    // RAM, then disk twice; woken by PCIe wake, general wake and alert in turn
    task automatic t_suspend();
        int wl[3] = '{4, 5, 8};
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys);
            suspend_ram_req <= (k == 0);
            suspend_disk_req <= (k != 0);
            @(posedge clk_sys);
            {suspend_ram_req, suspend_disk_req} <= 2'h0;
            @(negedge clk_sys);
            check(suspend_pending_n, 0);
            repeat (PC) @(negedge clk_sys);
            check({suspend_pending_n, suspend_ram_n, suspend_disk_n, soft_off_n}, {2'h2, k == 0, k == 0});
            press_see(wl[k], FC + 4, 5, 1);
            check({suspend_ram_n, suspend_disk_n}, 2'h3);
        end
    endtask
    // Alert drives the interrupt; processor shutdown drives thermal trip
    task automatic t_misc();
        fork
            car_inst.press(8, FC + 20);
            begin
                repeat (FC + 8) @(negedge clk_sys);
                check(system_mgmt_interrupt_n, 0);
            end
        join
        @(posedge clk_sys) cpu_thermal_shutdown <= 1'b1;
        @(posedge clk_sys) cpu_thermal_shutdown <= 1'b0;
        repeat (3) @(negedge clk_sys);
        check(thermal_trip_n, 0);
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_power();
        t_events();
        t_sources();
        t_rstbtn();
        t_suspend();
        t_misc();
        give_verdict();
    end
endmodule
